// ===== src/pmir_pkg.sv
// Purpose: shared constants and types of the power monitor register bank
// Assumes: clk_sys at 50 MHz
// Notes: pointer is three bits wide, so register offsets are three bits
package pmir_pkg;

   // register offsets
   localparam logic [2:0] REG_SENSE_HI = 3'h0;
   localparam logic [2:0] REG_SENSE_LO = 3'h1;
   localparam logic [2:0] REG_SUPPLY_HI = 3'h2;
   localparam logic [2:0] REG_SUPPLY_LO = 3'h3;
   localparam logic [2:0] REG_AUX_HI = 3'h4;
   localparam logic [2:0] REG_AUX_LO = 3'h5;
   localparam logic [2:0] REG_CTRL = 3'h6;
   localparam logic [2:0] REG_SPARE = 3'h7;

   // low result byte: nibble, busy flag, reserved zeros
   localparam int BUSY_BIT = 3;
   localparam logic [2:0] LOW_RESERVED = 3'h0;

   // operating settings reset value and writable bits
   localparam logic [7:0] CTRL_RESET = 8'h0c;
   localparam logic [7:0] CTRL_WR_MASK = 8'hfc;

   // snapshot channel codes
   localparam logic [1:0] CH_SENSE = 2'h0;
   localparam logic [1:0] CH_SUPPLY = 2'h1;
   localparam logic [1:0] CH_AUX = 2'h2;

   // bus addresses
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h67;
   localparam logic [6:0] MASS_WRITE_ADDR = 7'h66;

   // stuck-bus timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned STUCK_TIME_MS = 33;
   localparam int unsigned STUCK_CYCLES = STUCK_TIME_MS * (CLK_HZ / 1000);

   typedef struct packed {
      logic snapshotEnableBit;
      logic channelSelectHigh;
      logic channelSelectLow;
      logic testModeBit;
      logic pageAccessEnableBit;
      logic stuckBusTimerEnableBit;
      logic [1:0] reserved;
   } pmir_ctrl_type;

   typedef struct packed {
      logic done;
      logic [1:0] channel;
      logic [11:0] data;
   } pmir_conv_type;

endpackage : pmir_pkg

// ===== src/pmir_channel.sv
// Purpose: one converter result register pair with its snapshot busy flag
// Assumes: convIn.done is a one-cycle pulse from the converter
// Notes: busy set by an arming write wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module pmir_channel
#(
   parameter logic [1:0] CHANNEL = pmir_pkg::CH_SENSE
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire pmir_pkg::pmir_conv_type convIn,
   input wire logic convAllowed,
   input wire logic armPulse,
   input wire logic writeHigh,
   input wire logic writeLow,
   input wire logic [7:0] writeData,
   output logic [7:0] byteHigh,
   output logic [7:0] byteLow,
   output logic busy
);

   logic [11:0] data_reg;
   logic [11:0] data_next;
   logic busy_reg;
   logic busy_next;
   wire logic doneHere;

   assign doneHere = convIn.done & convAllowed & (convIn.channel == CHANNEL);

   always_comb
   begin
      data_next = data_reg;
      if (doneHere)
      begin
         data_next = convIn.data;
      end
      else
      begin
         if (writeHigh)
         begin
            data_next[11:4] = writeData;
         end
         if (writeLow)
         begin
            data_next[3:0] = writeData[7:4];
         end
      end
   end

   // busy follows the arming write and the conversion, never the written byte
   assign busy_next = armPulse | (busy_reg & ~doneHere);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_reg <= 12'h000;
         busy_reg <= 1'b0;
      end
      else if (ce)
      begin
         data_reg <= data_next;
         busy_reg <= busy_next;
      end
   end

   assign byteHigh = data_reg[11:4];
   assign byteLow = {data_reg[3:0], busy_reg, pmir_pkg::LOW_RESERVED};
   assign busy = busy_reg;

endmodule : pmir_channel
`default_nettype wire

// ===== src/pmir_top.sv
// Purpose: i2c slave register bank of a high-side power monitor
// Assumes: sclIn and sdaIn are synchronous to clk_sys
// Notes: sda is open drain; sdaOe high pulls the line low
`timescale 1ns/10ps
`default_nettype none
module pmir_top
#(
   parameter logic [6:0] DEV_ADDR = pmir_pkg::DEV_ADDR_DEFAULT,
   parameter int unsigned STUCK_CYCLES = pmir_pkg::STUCK_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire pmir_pkg::pmir_conv_type convIn,
   output logic adcRun,
   output logic adcSnapshot,
   output logic [1:0] adcChannel
);

   localparam int STUCK_W = $clog2(STUCK_CYCLES + 1);

   if (STUCK_CYCLES < 2)
   begin : g_bad_stuck
      $error("STUCK_CYCLES must be at least 2");
   end

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_WRITE,
      ST_WRITE_ACK,
      ST_READ,
      ST_READ_ACK
   } pmir_state_type;

   pmir_state_type state_reg;
   pmir_state_type state_next;
   logic [3:0] bitCnt_reg;
   logic [3:0] bitCnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [2:0] pointer_reg;
   logic [2:0] pointer_next;
   logic readMode_reg;
   logic readMode_next;
   logic masterAck_reg;
   logic masterAck_next;
   logic sdaOe_reg;
   logic sdaOe_next;
   logic sclPrev_reg;
   logic sdaPrev_reg;
   logic [STUCK_W-1:0] stuckCnt_reg;
   logic [STUCK_W-1:0] stuckCnt_next;
   pmir_pkg::pmir_ctrl_type ctrl_reg;
   pmir_pkg::pmir_ctrl_type ctrlWrite;
   logic adcRun_reg;
   logic adcSnapshot_reg;
   logic [1:0] adcChannel_reg;

   // bus condition decode
   wire logic sclRise;
   wire logic sclFall;
   wire logic startCond;
   wire logic stopCond;
   wire logic busLow;
   wire logic stuckExpire;
   wire logic stuckFull;
   wire logic byteDone;
   wire logic addrHit;
   wire logic stepEnable;
   wire logic [2:0] pointerStep;

   assign sclRise = sclIn & ~sclPrev_reg;
   assign sclFall = ~sclIn & sclPrev_reg;
   assign startCond = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
   assign stopCond = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;
   assign byteDone = sclFall & (bitCnt_reg == 4'h8);

   // general address answers both ways; mass address takes writes only
   assign addrHit = (shift_reg[7:1] == DEV_ADDR)
      | ((shift_reg[7:1] == pmir_pkg::MASS_WRITE_ADDR) & ~shift_reg[0]);

   // without page access the pointer stays on the addressed register
   assign stepEnable = ctrl_reg.pageAccessEnableBit;
   assign pointerStep = stepEnable ? pointer_reg + 3'h1 : pointer_reg;

   // stuck-bus timer: either line low runs it, both high clears it
   assign busLow = ~sclIn | ~sdaIn;
   assign stuckFull = (stuckCnt_reg == STUCK_W'(STUCK_CYCLES));
   assign stuckExpire = ctrl_reg.stuckBusTimerEnableBit & busLow
      & (stuckCnt_reg == STUCK_W'(STUCK_CYCLES - 1));
   assign stuckCnt_next = (busLow & ctrl_reg.stuckBusTimerEnableBit)
      ? (stuckFull ? stuckCnt_reg : stuckCnt_reg + STUCK_W'(1))
      : '0;

   // register write decode
   wire logic regWrite;
   wire logic resultWritable;
   wire logic [7:0] writeHit;
   wire logic ctrlWriteHit;
   wire logic snapArm;
   wire logic [1:0] armChannel;

   assign regWrite = (state_reg == ST_WRITE) & byteDone;
   assign writeHit = regWrite ? (8'h01 << pointer_reg) : 8'h00;
   assign resultWritable = ctrl_reg.testModeBit;
   assign ctrlWriteHit = writeHit[pmir_pkg::REG_CTRL];
   assign ctrlWrite = pmir_pkg::pmir_ctrl_type'(shift_reg & pmir_pkg::CTRL_WR_MASK);
   assign armChannel = {ctrlWrite.channelSelectHigh, ctrlWrite.channelSelectLow};
   assign snapArm = ctrlWriteHit & ctrlWrite.snapshotEnableBit;

   // converter results, one pair per channel
   wire logic convAllowed;
   wire logic [7:0] senseHigh;
   wire logic [7:0] senseLow;
   wire logic [7:0] supplyHigh;
   wire logic [7:0] supplyLow;
   wire logic [7:0] auxHigh;
   wire logic [7:0] auxLow;
   wire logic senseBusy;
   wire logic supplyBusyFlag;
   wire logic auxBusyFlag;
   wire logic anyBusy;

   assign convAllowed = ~ctrl_reg.testModeBit;

   pmir_channel #(
      .CHANNEL(pmir_pkg::CH_SENSE)
   ) u_sense (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .convIn(convIn),
      .convAllowed(convAllowed),
      .armPulse(snapArm & (armChannel == pmir_pkg::CH_SENSE)),
      .writeHigh(writeHit[pmir_pkg::REG_SENSE_HI] & resultWritable),
      .writeLow(writeHit[pmir_pkg::REG_SENSE_LO] & resultWritable),
      .writeData(shift_reg),
      .byteHigh(senseHigh),
      .byteLow(senseLow),
      .busy(senseBusy)
   );

   pmir_channel #(
      .CHANNEL(pmir_pkg::CH_SUPPLY)
   ) u_supply (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .convIn(convIn),
      .convAllowed(convAllowed),
      .armPulse(snapArm & (armChannel == pmir_pkg::CH_SUPPLY)),
      .writeHigh(writeHit[pmir_pkg::REG_SUPPLY_HI] & resultWritable),
      .writeLow(writeHit[pmir_pkg::REG_SUPPLY_LO] & resultWritable),
      .writeData(shift_reg),
      .byteHigh(supplyHigh),
      .byteLow(supplyLow),
      .busy(supplyBusyFlag)
   );

   pmir_channel #(
      .CHANNEL(pmir_pkg::CH_AUX)
   ) u_aux (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .convIn(convIn),
      .convAllowed(convAllowed),
      .armPulse(snapArm & (armChannel == pmir_pkg::CH_AUX)),
      .writeHigh(writeHit[pmir_pkg::REG_AUX_HI] & resultWritable),
      .writeLow(writeHit[pmir_pkg::REG_AUX_LO] & resultWritable),
      .writeData(shift_reg),
      .byteHigh(auxHigh),
      .byteLow(auxLow),
      .busy(auxBusyFlag)
   );

   assign anyBusy = senseBusy | supplyBusyFlag | auxBusyFlag;

   // read selection by pointer
   wire logic [7:0] regFile [8];
   wire logic [7:0] readByte;

   assign regFile[pmir_pkg::REG_SENSE_HI] = senseHigh;
   assign regFile[pmir_pkg::REG_SENSE_LO] = senseLow;
   assign regFile[pmir_pkg::REG_SUPPLY_HI] = supplyHigh;
   assign regFile[pmir_pkg::REG_SUPPLY_LO] = supplyLow;
   assign regFile[pmir_pkg::REG_AUX_HI] = auxHigh;
   assign regFile[pmir_pkg::REG_AUX_LO] = auxLow;
   assign regFile[pmir_pkg::REG_CTRL] = ctrl_reg;
   assign regFile[pmir_pkg::REG_SPARE] = 8'h00;
   assign readByte = regFile[pointer_reg];

   // bus sequencing
   always_comb
   begin
      state_next = state_reg;
      bitCnt_next = bitCnt_reg;
      shift_next = shift_reg;
      pointer_next = pointer_reg;
      readMode_next = readMode_reg;
      masterAck_next = masterAck_reg;
      sdaOe_next = sdaOe_reg;
      if (stuckExpire)
      begin
         state_next = ST_IDLE;
         sdaOe_next = 1'b0;
         pointer_next = 3'h0;
      end
      else if (stopCond)
      begin
         state_next = ST_IDLE;
         sdaOe_next = 1'b0;
         pointer_next = 3'h0;
      end
      else if (startCond)
      begin
         state_next = ST_ADDR;
         bitCnt_next = 4'h0;
         sdaOe_next = 1'b0;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
            end
            ST_ADDR, ST_CMD, ST_WRITE:
            begin
               if (sclRise)
               begin
                  shift_next = {shift_reg[6:0], sdaIn};
                  bitCnt_next = bitCnt_reg + 4'h1;
               end
               else if (byteDone)
               begin
                  bitCnt_next = 4'h0;
                  sdaOe_next = 1'b1;
                  if (state_reg == ST_ADDR)
                  begin
                     readMode_next = shift_reg[0];
                     state_next = addrHit ? ST_ADDR_ACK : ST_IDLE;
                     sdaOe_next = addrHit;
                  end
                  else if (state_reg == ST_CMD)
                  begin
                     pointer_next = shift_reg[2:0];
                     state_next = ST_CMD_ACK;
                  end
                  else
                  begin
                     state_next = ST_WRITE_ACK;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               if (sclFall)
               begin
                  if (readMode_reg)
                  begin
                     shift_next = readByte;
                     sdaOe_next = ~readByte[7];
                     bitCnt_next = 4'h1;
                     state_next = ST_READ;
                  end
                  else
                  begin
                     sdaOe_next = 1'b0;
                     state_next = ST_CMD;
                  end
               end
            end
            ST_CMD_ACK:
            begin
               if (sclFall)
               begin
                  sdaOe_next = 1'b0;
                  state_next = ST_WRITE;
               end
            end
            ST_WRITE_ACK:
            begin
               if (sclFall)
               begin
                  sdaOe_next = 1'b0;
                  pointer_next = pointerStep;
                  state_next = ST_WRITE;
               end
            end
            ST_READ:
            begin
               if (byteDone)
               begin
                  sdaOe_next = 1'b0;
                  state_next = ST_READ_ACK;
               end
               else if (sclFall)
               begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  sdaOe_next = ~shift_reg[6];
                  bitCnt_next = bitCnt_reg + 4'h1;
               end
            end
            ST_READ_ACK:
            begin
               if (sclRise)
               begin
                  masterAck_next = ~sdaIn;
                  if (~sdaIn)
                  begin
                     pointer_next = pointerStep;
                  end
               end
               else if (sclFall)
               begin
                  if (masterAck_reg)
                  begin
                     shift_next = readByte;
                     sdaOe_next = ~readByte[7];
                     bitCnt_next = 4'h1;
                     state_next = ST_READ;
                  end
                  else
                  begin
                     state_next = ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         pointer_reg <= 3'h0;
         readMode_reg <= 1'b0;
         masterAck_reg <= 1'b0;
         sdaOe_reg <= 1'b0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         bitCnt_reg <= bitCnt_next;
         shift_reg <= shift_next;
         pointer_reg <= pointer_next;
         readMode_reg <= readMode_next;
         masterAck_reg <= masterAck_next;
         sdaOe_reg <= sdaOe_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
         stuckCnt_reg <= '0;
         ctrl_reg <= pmir_pkg::CTRL_RESET;
      end
      else if (ce)
      begin
         sclPrev_reg <= sclIn;
         sdaPrev_reg <= sdaIn;
         stuckCnt_reg <= stuckCnt_next;
         if (ctrlWriteHit)
         begin
            ctrl_reg <= ctrlWrite;
         end
      end
   end

   // converter steering
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         adcRun_reg <= 1'b0;
         adcSnapshot_reg <= 1'b0;
         adcChannel_reg <= pmir_pkg::CH_SENSE;
      end
      else if (ce)
      begin
         adcRun_reg <= ~ctrl_reg.testModeBit
            & (~ctrl_reg.snapshotEnableBit | anyBusy);
         adcSnapshot_reg <= ctrl_reg.snapshotEnableBit;
         adcChannel_reg <= {ctrl_reg.channelSelectHigh, ctrl_reg.channelSelectLow};
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_reg;
   assign adcRun = adcRun_reg;
   assign adcSnapshot = adcSnapshot_reg;
   assign adcChannel = adcChannel_reg;

endmodule : pmir_top
`default_nettype wire

// ===== verification/pmir_top_sva.sv
// Purpose: port checks of the power monitor register bank
// Assumes: one clock domain, sda line has a pull-up
// Notes: bound to every pmir_top instance
`timescale 1ns/10ps
`default_nettype none
module pmir_top_sva
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire pmir_pkg::pmir_conv_type convIn,
   input wire logic adcRun,
   input wire logic adcSnapshot,
   input wire logic [1:0] adcChannel
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence startSeq;
      sclIn && sdaIn ##1 sclIn && !sdaIn;
   endsequence
   sequence stopSeq;
      sclIn && !sdaIn ##1 sclIn && sdaIn;
   endsequence
   chk_sda_zero: assert property (sdaOut == 1'b0)
      else $error("sda output value not zero");
   chk_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("sda drive changed while scl high");
   chk_start_quiet: assert property (startSeq |=> !sdaOe [*4])
      else $error("sda driven right after start");
   chk_stop_release: assert property (stopSeq |=> !sdaOe [*3])
      else $error("sda driven after stop");
   chk_run_reset: assert property ($rose(rst_n) |-> !adcSnapshot ##1 adcRun)
      else $error("converter not free running after reset");
   chk_ctrl_on_fall: assert property ($changed(adcChannel) |-> !sclIn)
      else $error("channel select changed while scl high");
   chk_snap_halt: assert property (convIn.done && adcSnapshot &&
      convIn.channel == adcChannel |-> ##2 !adcRun)
      else $error("converter not halted after snapshot");
   chk_code3_idle: assert property ((adcSnapshot && adcChannel == 2'h3) [*3] |-> !adcRun)
      else $error("converter runs on unused channel code");
endmodule : pmir_top_sva
bind pmir_top pmir_top_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .sclIn(sclIn),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .convIn(convIn), .adcRun(adcRun),
   .adcSnapshot(adcSnapshot), .adcChannel(adcChannel));
`default_nettype wire

// ===== verification/pmir_master.sv
// Purpose: bus master model driving scl and sda
// Assumes: released lines are pulled high by the bench
// Notes: every step inside the bus tasks is held two or four clocks, changes just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module pmir_master
(
   input wire logic clk_sys,
   input wire logic sdaLine,
   output var logic sclDrv,
   output var logic sdaDrv
);
   initial
   begin
      sclDrv = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : hold
   task automatic busStart();
      sdaDrv = 1'b1;
      hold(4);
      sclDrv = 1'b1;
      hold(4);
      sdaDrv = 1'b0;
      hold(4);
      sclDrv = 1'b0;
      hold(4);
   endtask : busStart
   task automatic busStop();
      sdaDrv = 1'b0;
      hold(4);
      sclDrv = 1'b1;
      hold(4);
      sdaDrv = 1'b1;
      hold(4);
   endtask : busStop
   task automatic bitOut(input logic v, output logic s);
      sdaDrv = v;
      hold(4);
      sclDrv = 1'b1;
      hold(2);
      s = sdaLine;
      hold(2);
      sclDrv = 1'b0;
      hold(2);
   endtask : bitOut
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitOut(b[i], s);
      bitOut(1'b1, s);
      ack = !s;
   endtask : sendByte
   task automatic getByte(input logic ackIt, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitOut(1'b1, s);
         b[i] = s;
      end
      bitOut(!ackIt, s);
   endtask : getByte
endmodule : pmir_master
`default_nettype wire

// ===== verification/pmir_top_bench.sv
// Purpose: self-checking bench of the power monitor register bank
// Assumes: master model on the bus, bench drives the converter side
// Notes: stuck-bus count shortened to 200 clocks, above the longest low run of a transfer
`timescale 1ns/10ps
`default_nettype none
module pmir_top_bench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sdaOut;
   logic sdaOe;
   logic adcRun;
   logic adcSnapshot;
   logic [1:0] adcChannel;
   logic sclDrv;
   logic sdaDrv;
   logic sdaWire;
   logic ack;
   logic [7:0] q[$];
   pmir_pkg::pmir_conv_type convIn = '0;
   int miscompares = 0;
   int n_compared = 0;
   always #10 clk_sys = ~clk_sys;
   assign sdaWire = sdaDrv & (sdaOe ? sdaOut : 1'b1);
   pmir_master m (.clk_sys(clk_sys), .sdaLine(sdaWire), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
   pmir_top #(.STUCK_CYCLES(200)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
      .sclIn(sclDrv), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .convIn(convIn),
      .adcRun(adcRun), .adcSnapshot(adcSnapshot), .adcChannel(adcChannel));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic busWrite(input logic [7:0] b[$]);
      m.busStart();
      m.sendByte({pmir_pkg::DEV_ADDR_DEFAULT, 1'b0}, ack);
      foreach (b[i])
         m.sendByte(b[i], ack);
      m.busStop();
   endtask : busWrite
   task automatic busRead(input logic [7:0] cmd, input int n);
      logic [7:0] d;
      q = {};
      m.busStart();
      m.sendByte({pmir_pkg::DEV_ADDR_DEFAULT, 1'b0}, ack);
      m.sendByte(cmd, ack);
      m.busStart();
      m.sendByte({pmir_pkg::DEV_ADDR_DEFAULT, 1'b1}, ack);
      check("read address ack", {7'h0, ack}, 8'h01);
      for (int i = 0; i < n; i++)
      begin
         m.getByte(i < n - 1, d);
         q.push_back(d);
      end
      m.busStop();
   endtask : busRead
   task automatic pulse(input logic [1:0] ch, input logic [11:0] v);
      convIn = '{1'b1, ch, v};
      @(posedge clk_sys);
      #1;
      convIn.done = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : pulse
   task automatic resetScen();
      check("run after reset", {7'h0, adcRun}, 8'h01);
      busRead(8'h06, 2);
      check("settings reset", q[0], 8'h0c);
      check("spare offset", q[1], 8'h00);
   endtask : resetScen
   task automatic testScen();
      busWrite({8'h06, 8'h1f});
      check("run in test", {7'h0, adcRun}, 8'h00);
      busWrite({8'hfa, 8'hab, 8'hcf, 8'h5a, 8'h6f});
      busRead(8'h02, 5);
      check("supply high", q[0], 8'hab);
      check("supply low", q[1], 8'hc0);
      check("aux high", q[2], 8'h5a);
      check("aux low", q[3], 8'h60);
      check("settings", q[4], 8'h1c);
      busWrite({8'h06, 8'h0c});
   endtask : testScen
   task automatic convScen();
      logic [11:0] v;
      for (int c = 0; c < 3; c++)
         pulse(2'(c), 12'h3a5 + 12'(c * 291));
      busRead(8'h00, 6);
      for (int c = 0; c < 3; c++)
      begin
         v = 12'h3a5 + 12'(c * 291);
         check("result high", q[2 * c], v[11:4]);
         check("result low", q[2 * c + 1], {v[3:0], 4'h0});
      end
   endtask : convScen
   task automatic snapScen();
      logic [7:0] d;
      for (int c = 0; c < 4; c++)
      begin
         busWrite({8'h06, 8'h8c | 8'(c << 5)});
         check("snapshot flag", {7'h0, adcSnapshot}, 8'h01);
         check("snapshot channel", {6'h0, adcChannel}, 8'(c));
         if (c < 3)
         begin
            busRead(8'(2 * c + 1), 1);
            check("busy set", q[0] & 8'h08, 8'h08);
            check("run in snapshot", {7'h0, adcRun}, 8'h01);
            pulse(2'(c), 12'h7e1);
            repeat (3) @(posedge clk_sys);
            #1;
            check("run after snapshot", {7'h0, adcRun}, 8'h00);
            busRead(8'(2 * c + 1), 1);
            check("busy clear", q[0], 8'h10);
         end
         else
            check("run unused code", {7'h0, adcRun}, 8'h00);
      end
      m.busStart();
      m.sendByte({pmir_pkg::DEV_ADDR_DEFAULT, 1'b1}, ack);
      m.getByte(1'b0, d);
      m.busStop();
      check("read after stop", d, 8'h7e);
   endtask : snapScen
   task automatic pageScen();
      busWrite({8'h06, 8'h04});
      busRead(8'h02, 2);
      check("page off first", q[0], 8'h7e);
      check("page off repeat", q[1], 8'h7e);
   endtask : pageScen
   task automatic stuckScen();
      for (int t = 0; t < 2; t++)
      begin
         m.busStart();
         m.hold(220);
         m.sendByte({pmir_pkg::DEV_ADDR_DEFAULT, 1'b0}, ack);
         m.busStop();
         check("ack after stall", {7'h0, ack}, 8'(t));
         busWrite({8'h06, 8'h08});
      end
   endtask : stuckScen
   task automatic results();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial
   begin
      repeat (16) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      resetScen();
      testScen();
      convScen();
      snapScen();
      pageScen();
      stuckScen();
      results();
   end
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      miscompares++;
      results();
   end
endmodule : pmir_top_bench
`default_nettype wire
